/* File: hdl/pcg_gate_bank.sv */
// peripheral clock gate bank: one enable register, twenty clock gates
// assumes a single system clock, synchronous active-low reset, axi4-lite master
//
// Behaviour
// - gate bit 0 is read only, reads one, resets to one.
// - bit 0 clock feeds fabric, bridge, core, configuration block, power unit.
// - writable gate bit at 0 stops its clock, at 1 passes it.
// - bit 1 gates boot rom clock, resets to 1.
// - bit 2 gates both sram banks together, resets to 1.
// - bit 3 gates flash controller register interface, resets to 1.
// - bit 4 gates flash array clock, resets to 1.
// - bit 5 gates first two-wire controller, resets to 0.
// - bit 6 gates gpio port and pin interrupt registers, resets to 1.
// - bit 7 gates pin routing matrix, resets to 1.
// - bit 8 gates state timer and pwm unit, resets to 0.
// - bit 9 gates self wake-up timer, resets to 0.
// - bit 10 gates multi-rate timer.
// - bit 11 gates first serial peripheral controller, resets to 0.
// - bit 12 gates second serial peripheral controller.
// - bit 13 gates crc engine, resets to 0.
// - bits 14 to 16 gate three serial transceivers in order, reset 0.
// - bit 17 gates windowed watchdog, resets to 0.
// - bit 18 gates pad configuration block, resets to 0.
// - bit 19 gates analog comparator digital interface, resets to 0.

// glitch-free gate cell: enable latched while the clock is low
// the latch closes as the clock rises, so a late enable waits a cycle
// latch-to-and path must settle inside one low half period
module pcg_clock_gate (
	// clock and enable
	input  wire logic clock,
	input  wire logic enable,
	// gated clock
	output logic      gated_clock
);
	logic en_latched;

	// transparent while low, so enable changes only land between pulses
	always_latch begin
		if (!clock) begin
			en_latched = enable;
		end
	end

	// and-gate after the latch never truncates a high phase
	assign gated_clock = clock & en_latched;

endmodule

module pcg_gate_bank
	import pcg_pkg::*;
(
	// system clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// axi4-lite write address
	input  wire logic [31:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// axi4-lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read address
	input  wire logic [31:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// axi4-lite read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// enables as held in the register, and the gated clocks
	output pcg_gate_type     gate_enable,
	output pcg_gate_type     gated_clocks
);

	// captured write request
	// either half may arrive first; the other waits in its holding flop
	logic        aw_full;
	logic        w_full;
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;

	// channel handshakes
	wire aw_take = awvalid & awready;
	wire w_take  = wvalid & wready;
	wire ar_take = arvalid & arready;
	wire b_done  = bvalid & bready;
	wire r_done  = rvalid & rready;

	// write fires once both halves are held and no response is pending
	wire do_write  = aw_full & w_full & ~bvalid;
	wire wr_hit    = (aw_addr_q == PCG_CTRL_ADDR);
	wire rd_hit    = (araddr == PCG_CTRL_ADDR);

	// protection bits carry no meaning for this block
	wire unused_prot = ^{awprot, arprot};

	// byte-lane merge of the write into the gate register
	wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire [19:0] lane_mask = strb_mask[19:0] & PCG_CTRL_WMASK;
	wire [19:0] cur_bits  = gate_enable;
	wire [19:0] merged    = (cur_bits & ~lane_mask) | (w_data_q[19:0] & lane_mask);
	// bit 0 is forced on whatever was written
	wire [19:0] next_gate = {merged[19:1], PCG_SYS_ON};

	// read view: bits above 19 read zero, bit 0 always one
	wire [31:0] ctrl_view = {12'h000, cur_bits[19:1], PCG_SYS_ON};

	// write address channel
	// awready drops on its own handshake and returns after the response
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aw_full   <= 1'b0;
			awready   <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
		end else if (aw_take) begin
			aw_full   <= 1'b1;
			awready   <= 1'b0;
			aw_addr_q <= awaddr;
		end else if (b_done) begin
			aw_full   <= 1'b0;
			awready   <= 1'b1;
		end else if (!aw_full && !bvalid) begin
			awready   <= 1'b1;
		end
	end

	// write data channel
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			w_full   <= 1'b0;
			wready   <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (w_take) begin
			w_full   <= 1'b1;
			wready   <= 1'b0;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (b_done) begin
			w_full   <= 1'b0;
			wready   <= 1'b1;
		end else if (!w_full && !bvalid) begin
			wready   <= 1'b1;
		end
	end

	// write response, held until the master takes it
	// unmapped addresses answer slverr and leave the enables alone
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp  <= PCG_RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
		end else if (b_done) begin
			bvalid <= 1'b0;
		end
	end

	// gate enable register; unspecified bits reset off
	// a write lands with the response, one edge after both halves are held
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gate_enable <= pcg_gate_type'(PCG_CTRL_RESET);
		end else if (do_write && wr_hit) begin
			gate_enable <= pcg_gate_type'(next_gate);
		end
	end

	// read channel: one cycle to answer, held until taken
	// read data is the enable word as it stood at the address edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= PCG_RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_hit ? ctrl_view : 32'h0000_0000;
			rresp   <= rd_hit ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
		end else if (r_done) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1 ^ (unused_prot & 1'b0);
		end
	end

	// one gate cell per block, each tied to its own enable bit except bit 0, tied on
	// gated clock bits gathered before driving the output struct
	wire [PCG_GATE_COUNT-1:0] gated_vec;

	// bit 0: fabric, bridge, core, configuration block, power unit
	// enable tied on so this clock can never stop, even before reset
	pcg_clock_gate u_gate_system_core (
		.clock       (clock),
		.enable      (PCG_SYS_ON),
		.gated_clock (gated_vec[0])
	);

	// bit 1: boot rom
	// on after reset so the boot code can run
	pcg_clock_gate u_gate_boot_rom (
		.clock       (clock),
		.enable      (gate_enable.boot_rom),
		.gated_clock (gated_vec[1])
	);

	// bit 2: both sram banks share one gate
	// on after reset; stopping it stalls every access to either bank
	pcg_clock_gate u_gate_sram_banks (
		.clock       (clock),
		.enable      (gate_enable.sram_banks_clock_gate),
		.gated_clock (gated_vec[2])
	);

	// bit 3: flash controller register interface
	// on after reset
	pcg_clock_gate u_gate_flash_ctrl_regs (
		.clock       (clock),
		.enable      (gate_enable.flash_ctrl_regs_clock_gate),
		.gated_clock (gated_vec[3])
	);

	// bit 4: flash memory array
	// on after reset; code fetch depends on it
	pcg_clock_gate u_gate_flash_array (
		.clock       (clock),
		.enable      (gate_enable.flash_array),
		.gated_clock (gated_vec[4])
	);

	// bit 5: first two-wire controller
	// off after reset until software enables it
	pcg_clock_gate u_gate_two_wire_first (
		.clock       (clock),
		.enable      (gate_enable.two_wire_ctrl_first),
		.gated_clock (gated_vec[5])
	);

	// bit 6: gpio port and pin interrupt registers together
	// on after reset
	pcg_clock_gate u_gate_gpio_pin_irq (
		.clock       (clock),
		.enable      (gate_enable.gpio_and_pin_irq),
		.gated_clock (gated_vec[6])
	);

	// bit 7: pin routing matrix
	// on after reset
	pcg_clock_gate u_gate_pin_routing (
		.clock       (clock),
		.enable      (gate_enable.pin_routing_matrix),
		.gated_clock (gated_vec[7])
	);

	// bit 8: state timer and pwm unit
	// off after reset
	pcg_clock_gate u_gate_state_timer (
		.clock       (clock),
		.enable      (gate_enable.state_timer_pwm_unit),
		.gated_clock (gated_vec[8])
	);

	// bit 9: self wake-up timer
	// off after reset
	pcg_clock_gate u_gate_wakeup_timer (
		.clock       (clock),
		.enable      (gate_enable.self_wakeup_timer),
		.gated_clock (gated_vec[9])
	);

	// bit 10: multi-rate timer
	// off after reset, our choice for an open reset value
	pcg_clock_gate u_gate_multi_rate (
		.clock       (clock),
		.enable      (gate_enable.multi_rate_timer_unit),
		.gated_clock (gated_vec[10])
	);

	// bit 11: first serial peripheral controller
	// off after reset
	pcg_clock_gate u_gate_serial_periph_first (
		.clock       (clock),
		.enable      (gate_enable.serial_periph_ctrl_first),
		.gated_clock (gated_vec[11])
	);

	// bit 12: second serial peripheral controller
	// off after reset, our choice for an open reset value
	pcg_clock_gate u_gate_serial_periph_second (
		.clock       (clock),
		.enable      (gate_enable.serial_periph_ctrl_second),
		.gated_clock (gated_vec[12])
	);

	// bit 13: crc engine
	// off after reset
	pcg_clock_gate u_gate_crc (
		.clock       (clock),
		.enable      (gate_enable.crc_engine),
		.gated_clock (gated_vec[13])
	);

	// bit 14: first serial transceiver
	// off after reset
	pcg_clock_gate u_gate_transceiver_first (
		.clock       (clock),
		.enable      (gate_enable.serial_transceiver_first),
		.gated_clock (gated_vec[14])
	);

	// bit 15: second serial transceiver
	// off after reset
	pcg_clock_gate u_gate_transceiver_second (
		.clock       (clock),
		.enable      (gate_enable.serial_transceiver_second),
		.gated_clock (gated_vec[15])
	);

	// bit 16: third serial transceiver
	// off after reset
	pcg_clock_gate u_gate_transceiver_third (
		.clock       (clock),
		.enable      (gate_enable.serial_transceiver_third),
		.gated_clock (gated_vec[16])
	);

	// bit 17: windowed watchdog
	// off after reset
	pcg_clock_gate u_gate_watchdog (
		.clock       (clock),
		.enable      (gate_enable.windowed_watchdog),
		.gated_clock (gated_vec[17])
	);

	// bit 18: pad configuration block
	// off after reset
	pcg_clock_gate u_gate_pad_config (
		.clock       (clock),
		.enable      (gate_enable.pad_configuration_block),
		.gated_clock (gated_vec[18])
	);

	// bit 19: analog comparator digital interface
	// off after reset
	pcg_clock_gate u_gate_comparator (
		.clock       (clock),
		.enable      (gate_enable.analog_comparator_iface),
		.gated_clock (gated_vec[19])
	);

	// one driver for the whole output struct
	assign gated_clocks = pcg_gate_type'(gated_vec);

endmodule

/* File: hdl/pcg_pkg.sv */
// constants and types of the peripheral clock gate bank
// assumes a 32-bit axi4-lite register bus on the system clock
package pcg_pkg;

	// register map, byte addresses on the system bus
	localparam logic [31:0] PCG_CTRL_ADDR  = 32'h4004_8080;
	localparam int          PCG_GATE_COUNT = 20;

	// reset value of the gate bank, bits 19 down to 0
	localparam logic [19:0] PCG_CTRL_RESET = 20'h000df;
	// bits that software may change; bit 0 stays fixed on
	localparam logic [19:0] PCG_CTRL_WMASK = 20'hffffe;
	// fixed value of the system clock gate bit
	localparam logic        PCG_SYS_ON     = 1'h1;

	// axi response codes
	localparam logic [1:0]  PCG_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  PCG_RESP_SLVERR = 2'h2;

	// one enable per clocked block, msb is gate bit 19
	typedef struct packed {
		logic analog_comparator_iface;
		logic pad_configuration_block;
		logic windowed_watchdog;
		logic serial_transceiver_third;
		logic serial_transceiver_second;
		logic serial_transceiver_first;
		logic crc_engine;
		logic serial_periph_ctrl_second;
		logic serial_periph_ctrl_first;
		logic multi_rate_timer_unit;
		logic self_wakeup_timer;
		logic state_timer_pwm_unit;
		logic pin_routing_matrix;
		logic gpio_and_pin_irq;
		logic two_wire_ctrl_first;
		logic flash_array;
		logic flash_ctrl_regs_clock_gate;
		logic sram_banks_clock_gate;
		logic boot_rom;
		logic system_core;
	} pcg_gate_type;

endpackage

/* File: test/pcg_props.sv */
// port checker for the gate bank
// assumes binding onto pcg_gate_bank, one clock domain
module pcg_props
	import pcg_pkg::*;
(
	// clock and reset
	input wire logic         clock,
	input wire logic         rst_n,
	// write channels
	input wire logic         awvalid,
	input wire logic         awready,
	input wire logic         wvalid,
	input wire logic         wready,
	input wire logic [1:0]   bresp,
	input wire logic         bvalid,
	input wire logic         bready,
	// read data channel
	input wire logic [31:0]  rdata,
	input wire logic [1:0]   rresp,
	input wire logic         rvalid,
	input wire logic         rready,
	// gate enables and gated clocks
	input wire pcg_gate_type gate_enable,
	input wire pcg_gate_type gated_clocks
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// both write halves taken at one edge
	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	// a successful write answer
	sequence s_wr_ok;
		$rose(bvalid) && bresp == PCG_RESP_OKAY;
	endsequence

	property p_sys; gate_enable.system_core == PCG_SYS_ON; endproperty
	a_sys: assert property (p_sys) else $error("system gate off");
	property p_rst; disable iff (1'b0) !rst_n |=> gate_enable == PCG_CTRL_RESET; endproperty
	a_rst: assert property (p_rst) else $error("reset enables");
	// gated clock high phase follows the enable held since the last low phase
	property p_gate; @(negedge clock) disable iff (!rst_n) gated_clocks == $past(gate_enable);
	endproperty
	a_gate: assert property (p_gate) else $error("gated clock");
	// read word is the enable word as sampled at the address edge
	property p_rd; $rose(rvalid) && rresp == PCG_RESP_OKAY |->
		rdata == {12'h000, $past(gate_enable)}; endproperty
	a_rd: assert property (p_rd) else $error("read value");
	property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_chg; !$stable(gate_enable) |-> s_wr_ok; endproperty
	a_chg: assert property (p_chg) else $error("enable change");
	property p_bad; $rose(bvalid) && bresp != PCG_RESP_OKAY |-> $stable(gate_enable); endproperty
	a_bad: assert property (p_bad) else $error("refused write");
	property p_blat; s_wr_take |-> ##2 bvalid; endproperty
	a_blat: assert property (p_blat) else $error("write answer late");
	property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
endmodule

bind pcg_gate_bank pcg_props u_props (.clock, .rst_n, .awvalid, .awready, .wvalid, .wready,
	.bresp, .bvalid, .bready, .rdata, .rresp, .rvalid, .rready, .gate_enable, .gated_clocks);

/* File: test/pcg_gate_bank_tb_top.sv */
// bench: bus tasks, shadow model of the enables, checks
// assumes pcg_pkg, pcg_gate_bank and pcg_props compiled before
module pcg_gate_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pcg_pkg::*;

	// bus and gate signals
	logic         clock = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic         arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
	logic [31:0]  awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic [3:0]   wstrb = 0;
	logic [2:0]   awprot = 0, arprot = 0;
	logic [1:0]   bresp, rresp;
	logic [19:0]  m = PCG_CTRL_RESET;
	pcg_gate_type ge, gc;
	int           n_errors = 0, tests_run = 0, i;

	pcg_gate_bank dut (.clock, .rst_n, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .gate_enable(ge), .gated_clocks(gc));

	// 250 mhz clock
	initial forever #2 clock = ~clock;

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one write; model keeps only writable bits of strobed bytes
	task automatic wr(logic [31:0] a, logic [31:0] d, logic [3:0] s);
		logic        aw;
		logic        w;
		logic [19:0] k;
		aw = 1;
		w = 1;
		k = {{4{s[2]}}, {8{s[1]}}, {8{s[0]}}} & PCG_CTRL_WMASK;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge clock);
			aw = aw & ~awready;
			w = w & ~wready;
			awvalid <= aw;
			wvalid <= w;
		end while (aw || w);
		repeat ($urandom % 3) @(posedge clock);
		bready <= 1;
		do @(posedge clock); while (!bvalid);
		bready <= 0;
		if (a == PCG_CTRL_ADDR) m = m & ~k | d[19:0] & k;
		chk("bresp", a == PCG_CTRL_ADDR ? PCG_RESP_OKAY : PCG_RESP_SLVERR, bresp);
		chk("enables", m, ge);
		// high phase shows the enables latched during the low phase before it
		#1;
		chk("gated", m, gc);
		@(posedge clock);
	endtask

	// one read, compared with the model
	task automatic rd(logic [31:0] a);
		araddr <= a;
		arvalid <= 1;
		do @(posedge clock); while (!arready);
		arvalid <= 0;
		repeat ($urandom % 3) @(posedge clock);
		rready <= 1;
		do @(posedge clock); while (!rvalid);
		rready <= 0;
		chk("rdata", a == PCG_CTRL_ADDR ? {12'h0, m} : 32'h0, rdata);
		chk("rresp", a == PCG_CTRL_ADDR ? PCG_RESP_OKAY : PCG_RESP_SLVERR, rresp);
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles needed
	initial begin
		#40000;
		n_errors++;
		close_out();
	end

	// main sequence
	initial begin
		i = $urandom(11);
		repeat (12) @(posedge clock);
		rst_n <= 1;
		@(posedge clock);
		chk("reset", PCG_CTRL_RESET, ge);
		rd(PCG_CTRL_ADDR);
		$display("test reset done");
		wr(PCG_CTRL_ADDR, 32'h0, 4'hf);
		rd(PCG_CTRL_ADDR);
		wr(PCG_CTRL_ADDR, 32'hffffffff, 4'hf);
		$display("test extremes done");
		for (i = 0; i < 12; i++) begin
			wr(PCG_CTRL_ADDR, $urandom, 4'($urandom));
			rd(PCG_CTRL_ADDR);
		end
		$display("test random done");
		wr(PCG_CTRL_ADDR + 4, 32'hffffffff, 4'hf);
		rd(PCG_CTRL_ADDR + 4);
		$display("test unmapped done");
		rst_n <= 0;
		repeat (2) @(posedge clock);
		rst_n <= 1;
		m = PCG_CTRL_RESET;
		@(posedge clock);
		chk("reset again", PCG_CTRL_RESET, ge);
		rd(PCG_CTRL_ADDR);
		$display("test second reset done");
		close_out();
	end
endmodule
